// ### rsa_spi_regs.sv
/*
  Serial slave register port of the radio: decodes short and long commands
  from the host, writes and reads the control register file.
  Assumes sck runs at most clk/16, idles low, and select_n frames each
  transaction; status inputs come from logic on clk.
*/
`timescale 1ns/1ps
module rsa_spi_regs
  import rsa_pkg::*;
#(
  parameter int NREG = RSA_NREG
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 sck,
  input  wire logic                 sdi,
  input  wire logic                 select_n,
  output logic                      sdo,
  output logic                      sdo_oe,
  input  wire logic [7:0]           tx_status,
  input  wire logic [7:0]           irq_flags,
  input  wire logic                 rssi_ready,
  input  wire logic [5:0]           gpio_in,
  output logic      [NREG-1:0][7:0] reg_q,
  output logic                      flush_pulse
);

  // synchronised pins
  logic [2:0] pin_s;
  logic [5:0] gpio_s;
  logic       sck_s;
  logic       sdi_s;
  logic       sel_n_s;
  logic       sck_d_r;
  logic       rise;
  logic       fall;

  // frame state
  rsa_phase_t phase_r;
  logic [4:0]  bit_cnt_r;
  logic        long_r;
  logic [14:0] cmd_r;
  logic [7:0]  rx_r;
  logic [7:0]  tx_r;
  logic        wr_r;
  logic        hit_r;
  rsa_reg_t    idx_r;
  logic        sdo_r;
  logic        sdo_oe_r;
  logic        flush_r;

  // command decode
  logic        cmd_end;
  logic        cur_wr;
  logic [9:0]  cur_addr;
  logic [5:0]  look;
  logic [7:0]  rd_val;
  logic        wr_strobe;
  logic [7:0]  wr_byte;

  rsa_sync #(
    .W    (3),
    .INIT (3'b100)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({select_n, sdi, sck}),
    .q     (pin_s)
  );

  rsa_sync #(
    .W    (6),
    .INIT (6'h00)
  ) u_gpio_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (gpio_in),
    .q     (gpio_s)
  );

  assign sck_s   = pin_s[0];
  assign sdi_s   = pin_s[1];
  assign sel_n_s = pin_s[2];

  // edge detect on the settled clock; only mode 0,0 edges are meaningful
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sck_d_r <= 1'b0;
    else        sck_d_r <= sck_s;
  end

  assign rise = ~sel_n_s & sck_s & ~sck_d_r;  // RULE1
  assign fall = ~sel_n_s & ~sck_s & sck_d_r;  // RULE1

  // map a space and offset onto a register; bit 5 flags a hit
  function automatic logic [5:0] lookup(input logic lng, input logic [9:0] a);
    logic [5:0] r;
    r = 6'h00;
    if (!lng) begin
      case (a[5:0])
        `RSA_SA_RXCTL:   r = {1'b1, RSA_R_RXCTL};
        `RSA_SA_PANL:    r = {1'b1, RSA_R_PANL};
        `RSA_SA_PANH:    r = {1'b1, RSA_R_PANH};
        `RSA_SA_SADL:    r = {1'b1, RSA_R_SADL};
        `RSA_SA_SADH:    r = {1'b1, RSA_R_SADH};
        `RSA_SA_FLUSH:   r = {1'b1, RSA_R_FLUSH};
        `RSA_SA_TXOUT:   r = {1'b1, RSA_R_TXOUT};
        `RSA_SA_ISR:     r = {1'b1, RSA_R_ISR};
        `RSA_SA_IMASK:   r = {1'b1, RSA_R_IMASK};
        `RSA_SA_GPIO:    r = {1'b1, RSA_R_GPIO};
        `RSA_SA_TRIS:    r = {1'b1, RSA_R_TRIS};
        `RSA_SA_CCA:     r = {1'b1, RSA_R_CCA};
        `RSA_SA_RSSI:    r = {1'b1, RSA_R_RSSI};
        default: begin
          // the eight extended-address bytes sit in one contiguous run
          if (a[5:0] >= `RSA_SA_EXT0 && a[5:0] < `RSA_SA_EXT0 + 6'h08)
            r = 6'h20 | 6'(RSA_R_EXT0 + (a[5:0] - `RSA_SA_EXT0));
        end
      endcase
    end else begin
      case (a)
        `RSA_LA_CHAN:   r = {1'b1, RSA_R_CHAN};
        `RSA_LA_SYNTH:  r = {1'b1, RSA_R_SYNTH};
        `RSA_LA_TXPWR:  r = {1'b1, RSA_R_TXPWR};
        `RSA_LA_FILT:   r = {1'b1, RSA_R_FILT};
        `RSA_LA_SLEEP:  r = {1'b1, RSA_R_SLEEP};
        `RSA_LA_OSC:    r = {1'b1, RSA_R_OSC};
        `RSA_LA_CLKOUT: r = {1'b1, RSA_R_CLKOUT};
        default:          r = 6'h00;
      endcase
    end
    return r;
  endfunction : lookup

  // writable bits of each register; bits outside the mask are not stored
  function automatic logic [7:0] wmask(input rsa_reg_t ix);
    logic [7:0] m;
    m = `RSA_WM_FULL;
    case (ix)
      RSA_R_FLUSH:    m = `RSA_WM_FLUSH;
      RSA_R_TXOUT:    m = `RSA_WM_NONE;
      RSA_R_ISR:      m = `RSA_WM_NONE;
      RSA_R_GPIO:     m = `RSA_WM_GPIO;
      RSA_R_TRIS:     m = `RSA_WM_GPIO;
      RSA_R_CCA:      m = `RSA_WM_CCA;
      RSA_R_RSSI:     m = `RSA_WM_RSSI;
      RSA_R_CHAN:     m = `RSA_WM_CHAN;
      RSA_R_SYNTH:    m = `RSA_WM_SYNPWR;
      RSA_R_TXPWR:    m = `RSA_WM_SYNPWR;
      RSA_R_FILT:     m = `RSA_WM_FILT;
      RSA_R_SLEEP:    m = `RSA_WM_SLEEP;
      RSA_R_OSC:      m = `RSA_WM_OSC;
      RSA_R_CLKOUT:   m = `RSA_WM_CLKOUT;
      default:        m = `RSA_WM_FULL;
    endcase
    return m;
  endfunction : wmask

  // command ends after bit 7 (short) or after the pad nibble (long)
  assign cmd_end = (phase_r == RSA_PH_CMD) &&
                   ((!long_r && bit_cnt_r == `RSA_SHORT_CMD_END) ||   // RULE6
                    ( long_r && bit_cnt_r == `RSA_LONG_CMD_END));     // RULE7 RULE10
  // long: bits 1..10 address, bit 11 direction, 12..15 ignored
  assign cur_addr = long_r ? cmd_r[13:4]                          // RULE7
                           : {4'h0, cmd_r[5:0]};                  // RULE6
  assign cur_wr   = long_r ? cmd_r[3] : sdi_s;                    // RULE10
  assign look     = lookup(long_r, cur_addr);

  // read value: stored bits under mask, live status for read-only fields
  always_comb begin
    rd_val = 8'h00;                                              // RULE9
    if (look[5]) begin
      rd_val = reg_q[look[4:0]] & wmask(rsa_reg_t'(look[4:0]));  // RULE9
      case (rsa_reg_t'(look[4:0]))
        RSA_R_TXOUT:  rd_val = tx_status;
        RSA_R_ISR:    rd_val = irq_flags;
        RSA_R_GPIO:   rd_val = {2'b00, gpio_s};
        RSA_R_RSSI:   rd_val[`RSA_RSSI_RDY_BIT] = rssi_ready;
        default:      rd_val = rd_val;
      endcase
    end
  end

  // frame sequencer, restarted whenever select is released
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r   <= RSA_PH_CMD;
      bit_cnt_r <= 5'd0;
      long_r    <= 1'b0;
      cmd_r     <= 15'h0000;
      rx_r      <= 8'h00;
      wr_r      <= 1'b0;
      hit_r     <= 1'b0;
      idx_r     <= RSA_R_RXCTL;
    end else if (sel_n_s) begin
      phase_r   <= RSA_PH_CMD;  // RULE5
      bit_cnt_r <= 5'd0;
      long_r    <= 1'b0;
    end else if (rise) begin
      unique case (phase_r)
        RSA_PH_CMD: begin
          cmd_r     <= {cmd_r[13:0], sdi_s};  // RULE3
          bit_cnt_r <= bit_cnt_r + 5'd1;
          if (bit_cnt_r == 5'd0) long_r <= sdi_s;
          if (cmd_end) begin
            phase_r <= RSA_PH_DATA;  // RULE8
            wr_r    <= cur_wr;
            hit_r   <= look[5];
            idx_r   <= rsa_reg_t'(look[4:0]);
          end
        end
        RSA_PH_DATA: begin
          rx_r      <= {rx_r[6:0], sdi_s};  // RULE11
          bit_cnt_r <= bit_cnt_r + 5'd1;
          if (bit_cnt_r[2:0] == 3'd7) phase_r <= RSA_PH_DONE;
        end
        RSA_PH_DONE: begin
          // trailing bytes are ignored until select rises
          phase_r <= RSA_PH_DONE;
        end
      endcase
    end
  end

  // write strobe on the eighth data bit, MSB arrived first
  assign wr_strobe = rise && phase_r == RSA_PH_DATA && bit_cnt_r[2:0] == 3'd7 &&
                     wr_r && hit_r;                              // RULE11
  assign wr_byte   = {rx_r[6:0], sdi_s};

  // register file, one flop group per entry
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      localparam rsa_reg_t IX = rsa_reg_t'(g);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          reg_q[g] <= (IX == RSA_R_IMASK) ? `RSA_RST_IMASK : `RSA_RST_DEFAULT;
        end else if (wr_strobe && idx_r == IX) begin
          // unimplemented and read-only bits stay zero
          reg_q[g] <= wr_byte & wmask(IX);  // RULE9 RULE11
        end
      end
    end
  endgenerate

  // flush bit acts once on write and is never stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) flush_r <= 1'b0;
    else        flush_r <= wr_strobe && idx_r == RSA_R_FLUSH &&
                           wr_byte[`RSA_FLUSH_BIT];
  end

  assign flush_pulse = flush_r;

  // read shifter: loaded at the command's last edge, shifted out on falls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_r  <= 8'h00;
      sdo_r <= 1'b0;
    end else if (sel_n_s) begin
      tx_r  <= 8'h00;
      sdo_r <= 1'b0;
    end else if (rise && cmd_end) begin
      tx_r  <= cur_wr ? 8'h00 : rd_val;  // RULE8
    end else if (fall) begin
      if (phase_r == RSA_PH_DATA) begin
        sdo_r <= tx_r[7];              // RULE4 RULE8
        tx_r  <= {tx_r[6:0], 1'b0};
      end else begin
        sdo_r <= 1'b0;                 // RULE4
      end
    end
  end

  // drive the output only while selected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sdo_oe_r <= 1'b0;
    else        sdo_oe_r <= ~sel_n_s;  // RULE5
  end

  assign sdo    = sdo_r;
  assign sdo_oe = sdo_oe_r;

endmodule : rsa_spi_regs

// ### rsa_defines.svh
/*
  Constants of the radio serial register port: register offsets in the
  short and long spaces, writable-bit masks, reset values, frame counts.
  Assumes it is included by bare name from the package only.

// Operation
// RULE1: serial port works in clock mode 0,0 only
// RULE2: host keeps serial clock low when idle
// RULE3: input bits captured on rising clock edges
// RULE4: output line changes on falling clock edges
// RULE5: select low for whole transaction, then high
// RULE6: short access: 0, 6-bit address, direction bit
// RULE7: long access: 1, 10-bit address, direction bit
// RULE8: eight data bits follow command, MSB first
// RULE9: unimplemented register bits always read zero
// RULE10: four pad bits after long command ignored
// RULE11: write data follows command, stored in register
// RULE12: host waits for synthesizer lock before radio use
// RULE13: host never alters reserved registers or bits
// RULE14: buffers use long format; receive buffer read-only
*/
`ifndef RSA_DEFINES_SVH
`define RSA_DEFINES_SVH

// short space offsets (6 bits)
`define RSA_SA_RXCTL      6'h00
`define RSA_SA_PANL       6'h01
`define RSA_SA_PANH       6'h02
`define RSA_SA_SADL       6'h03
`define RSA_SA_SADH       6'h04
`define RSA_SA_EXT0       6'h05
`define RSA_SA_FLUSH      6'h0D
`define RSA_SA_TXOUT      6'h24
`define RSA_SA_ISR        6'h31
`define RSA_SA_IMASK      6'h32
`define RSA_SA_GPIO       6'h33
`define RSA_SA_TRIS       6'h34
`define RSA_SA_CCA        6'h3A
`define RSA_SA_RSSI       6'h3E

// long space offsets (10 bits)
`define RSA_LA_CHAN       10'h200
`define RSA_LA_SYNTH      10'h203
`define RSA_LA_TXPWR      10'h206
`define RSA_LA_FILT       10'h209
`define RSA_LA_SLEEP      10'h20A
`define RSA_LA_OSC        10'h20B
`define RSA_LA_CLKOUT     10'h220

// implemented and writable bits; the rest read zero except live status fields
`define RSA_WM_FULL       8'hFF
`define RSA_WM_FLUSH      8'h7E
`define RSA_WM_NONE       8'h00
`define RSA_WM_GPIO       8'h3F
`define RSA_WM_CCA        8'hFC
`define RSA_WM_RSSI       8'hFE
`define RSA_WM_CHAN       8'hF0
`define RSA_WM_SYNPWR     8'hF8
`define RSA_WM_FILT       8'hB8
`define RSA_WM_SLEEP      8'hC3
`define RSA_WM_OSC        8'h10
`define RSA_WM_CLKOUT     8'h90

// field positions
`define RSA_FLUSH_BIT     0
`define RSA_RSSI_RDY_BIT  0

// reset values
`define RSA_RST_DEFAULT   8'h00
`define RSA_RST_IMASK     8'hFF

// frame bit counts (index of the last command bit)
`define RSA_SHORT_CMD_END 5'd7
`define RSA_LONG_CMD_END  5'd15
`define RSA_SHORT_ADR_W   6
`define RSA_LONG_ADR_W    10

`endif

// ### rsa_pkg.sv
/*
  Types of the radio serial register port: frame phase and register index.
  Assumes rsa_defines.svh is on the include path.
*/
package rsa_pkg;
  `include "rsa_defines.svh"

  typedef enum logic [1:0] {
    RSA_PH_CMD,
    RSA_PH_DATA,
    RSA_PH_DONE
  } rsa_phase_t;

  typedef enum logic [4:0] {
    RSA_R_RXCTL, RSA_R_PANL, RSA_R_PANH, RSA_R_SADL, RSA_R_SADH,
    RSA_R_EXT0, RSA_R_EXT1, RSA_R_EXT2, RSA_R_EXT3,
    RSA_R_EXT4, RSA_R_EXT5, RSA_R_EXT6, RSA_R_EXT7,
    RSA_R_FLUSH, RSA_R_TXOUT, RSA_R_ISR, RSA_R_IMASK, RSA_R_GPIO,
    RSA_R_TRIS, RSA_R_CCA, RSA_R_RSSI, RSA_R_CHAN,
    RSA_R_SYNTH, RSA_R_TXPWR, RSA_R_FILT, RSA_R_SLEEP,
    RSA_R_OSC, RSA_R_CLKOUT
  } rsa_reg_t;

  localparam int RSA_NREG = 28;
endpackage : rsa_pkg

// ### rsa_sync.sv
/*
  Input synchroniser for pins: three stage flip-flops and an output flip-flop per bit, output follows
  once the second and third stages agree.
  Assumes inputs are asynchronous to clk; INIT is the idle pin level.
*/
`timescale 1ns/1ps
module rsa_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      // stage one feeds only stage two
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r <= INIT[i];
          s2_r <= INIT[i];
          s3_r <= INIT[i];
          q[i] <= INIT[i];
        end else begin
          s1_r <= d[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) q[i] <= s3_r; // glitch shorter than a cycle is dropped
        end
      end
    end
  endgenerate
endmodule : rsa_sync

// ### rsa_chk.sv
/*
  Checker of the serial register port, bound to rsa_spi_regs.
  Assumes one clock and a host whose sck phases last at least 8 clk.
*/
`timescale 1ns/1ps
module rsa_chk
  import rsa_pkg::*;
#(
  parameter int NREG = RSA_NREG
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 sck,
  input wire logic                 sdi,
  input wire logic                 select_n,
  input wire logic                 sdo,
  input wire logic                 sdo_oe,
  input wire logic [7:0]           tx_status,
  input wire logic [7:0]           irq_flags,
  input wire logic                 rssi_ready,
  input wire logic [5:0]           gpio_in,
  input wire logic [NREG-1:0][7:0] reg_q,
  input wire logic                 flush_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a settled deselect and a settled high phase of the serial clock
  sequence s_idle; select_n [*8]; endsequence
  sequence s_sck_hi; sck [*6]; endsequence
  property p_idle_quiet; s_idle |-> !sdo_oe && !sdo; endproperty
  property p_oe_on; $fell(select_n) |-> ##[2:8] sdo_oe; endproperty
  property p_sdo_hold; s_sck_hi |-> $stable(sdo); endproperty
  property p_sdo_off; !sdo_oe |-> !sdo; endproperty
  property p_pulse_one; flush_pulse |=> !flush_pulse; endproperty
  property p_pulse_sel; flush_pulse |-> !select_n; endproperty
  property p_reg_idle; s_idle |=> $stable(reg_q); endproperty
  // unimplemented bits of CHAN and GPIO must never hold a one
  property p_unimpl;
    reg_q[RSA_R_CHAN][3:0] == 4'h0 && reg_q[RSA_R_GPIO][7:6] == 2'h0;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("sdo driven while deselected");
  a_oe_on: assert property (p_oe_on)
    else $error("sdo enable late after select");
  a_sdo_hold: assert property (p_sdo_hold)
    else $error("sdo moved while sck high");
  a_sdo_off: assert property (p_sdo_off)
    else $error("sdo high while disabled");
  a_pulse_one: assert property (p_pulse_one)
    else $error("flush pulse longer than one clk");
  a_pulse_sel: assert property (p_pulse_sel)
    else $error("flush pulse outside a frame");
  a_reg_idle: assert property (p_reg_idle)
    else $error("register changed while deselected");
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented bit stored");
endmodule : rsa_chk

bind rsa_spi_regs rsa_chk #(.NREG(NREG)) rsa_chk_i (.clk(clk), .rst_n(rst_n), .sck(sck),
  .sdi(sdi), .select_n(select_n), .sdo(sdo), .sdo_oe(sdo_oe), .tx_status(tx_status),
  .irq_flags(irq_flags), .rssi_ready(rssi_ready), .gpio_in(gpio_in), .reg_q(reg_q),
  .flush_pulse(flush_pulse));

// ### rsa_host.sv
/*
  Host master model: mode 0 frames, short and long commands.
  Assumes clk is the device clock; sck phases last 10 clk.
*/
`timescale 1ns/1ps
module rsa_host (
  input  wire logic clk,
  input  wire logic sdo,
  output logic      sck,
  output logic      sdi,
  output logic      select_n
);
  // idle: clock low, deselected
  initial begin
    sck      = 1'b0;
    sdi      = 1'b0;
    select_n = 1'b1;
  end

  // one framed access; last eight sampled bits return as read data
  task automatic access(input logic lng, input logic [9:0] adr, input logic wr,
                        input logic [7:0] wd, output logic [7:0] rd);
    logic [23:0] f;
    int          n;
    if (lng) begin
      f = {1'b1, adr, wr, 4'h0, wd};
      n = 24;
    end else begin
      f = {8'h00, 1'b0, adr[5:0], wr, wd};
      n = 16;
    end
    rd = 8'h00;
    @(negedge clk) select_n = 1'b0;
    repeat (5) @(negedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      sdi = f[i];
      repeat (10) @(negedge clk);
      sck = 1'b1;
      rd  = {rd[6:0], sdo};
      repeat (10) @(negedge clk);
      sck = 1'b0;
    end
    repeat (10) @(negedge clk);
    select_n = 1'b1;
    sdi      = ~sdi; // released line does not keep its last value
    repeat (8) @(negedge clk);
  endtask : access
endmodule : rsa_host

// ### tb_top.sv
/*
  Testbench of the serial register port: write and read through the host model.
  Assumes rsa_pkg compiled first and the checker bound to the design.
*/
`timescale 1ns/1ps
module tb_top
  import rsa_pkg::*;
;
  logic                     clk, rst_n, sck, sdi, select_n, sdo, sdo_oe, rssi_ready;
  logic                     flush_pulse;
  logic [7:0]               tx_status, irq_flags, rd;
  logic [5:0]               gpio_in;
  logic [RSA_NREG-1:0][7:0] reg_q;
  logic [26:0]              tbl [10];
  int                       err_total, n_tests, n_flush;

  rsa_spi_regs rsa_spi_regs_i (.clk(clk), .rst_n(rst_n), .sck(sck), .sdi(sdi),
    .select_n(select_n), .sdo(sdo), .sdo_oe(sdo_oe), .tx_status(tx_status),
    .irq_flags(irq_flags), .rssi_ready(rssi_ready), .gpio_in(gpio_in), .reg_q(reg_q),
    .flush_pulse(flush_pulse));
  rsa_host rsa_host_i (.clk(clk), .sdo(sdo), .sck(sck), .sdi(sdi), .select_n(select_n));

  // 50 MHz clock
  always #10 clk = ~clk;
  always @(posedge clk) if (flush_pulse === 1'b1) n_flush++;

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // watchdog well beyond the roughly 8.5k clk of traffic
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    tx_status = 8'h3C;
    irq_flags = 8'h81;
    rssi_ready = 1'b1;
    gpio_in = 6'h2A;
    err_total = 0;
    n_tests = 0;
    n_flush = 0;
    // long, address, write data, expected read back
    tbl = '{{1'b0, 10'h001, 8'hA5, 8'hA5}, {1'b0, 10'h00C, 8'h5A, 8'h5A},
            {1'b0, 10'h00D, 8'h1F, 8'h1E}, {1'b0, 10'h024, 8'hFF, 8'h3C},
            {1'b0, 10'h033, 8'h3F, 8'h2A}, {1'b0, 10'h03E, 8'h80, 8'h81},
            {1'b0, 10'h010, 8'h77, 8'h00}, {1'b1, 10'h200, 8'hFF, 8'hF0},
            {1'b1, 10'h220, 8'h1F, 8'h10}, {1'b1, 10'h209, 8'hCF, 8'h88}};
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk8(reg_q[RSA_R_IMASK], 8'hFF);
    chk8({7'h0, sdo_oe}, 8'h00);
    rsa_host_i.access(1'b0, 10'h032, 1'b0, 8'hC3, rd);
    chk8(rd, 8'hFF);
    rsa_host_i.access(1'b0, 10'h031, 1'b0, 8'h00, rd);
    chk8(rd, 8'h81);
    // write then read back each entry, back to back
    for (int k = 0; k < 10; k++) begin
      rsa_host_i.access(tbl[k][26], tbl[k][25:16], 1'b1, tbl[k][15:8], rd);
      rsa_host_i.access(tbl[k][26], tbl[k][25:16], 1'b0, 8'h5C, rd);
      chk8(rd, tbl[k][7:0]);
    end
    chk8(reg_q[RSA_R_PANL], 8'hA5);
    chk8(reg_q[RSA_R_EXT7], 8'h5A);
    chk8(n_flush[7:0], 8'h01);
    give_verdict();
  end
endmodule : tb_top
